// File: bench/pipe_model.sv
// Behavioural model of the execute pipeline that drives the register file
`timescale 1ns/100ps
`default_nettype none
module pipe_model (
   input wire logic clk_in, // Core clock
   input wire logic [31:0] rdata_in, // Read data
   input wire logic fault_in, // Illegal write pulse
   input wire logic block_in, // Mask decision
   output logic [4:0] addr_out, // Register index
   output logic [31:0] wdata_out, // Write data
   output logic wr_out, // Write strobe
   output logic rd_out, // Read strobe
   output logic low_out, // Short encoding access
   output logic call_out, // Call pulse
   output logic [31:0] ret_out, // Return address
   output logic enter_out, // Exception entry pulse
   output logic [8:0] num_out, // Exception number
   output logic back_out, // Exception return pulse
   output logic iv_out, // Request pending
   output logic inmi_out, // Unmaskable request
   output logic ihf_out, // Hard fault request
   output logic [8:0] iprio_out // Request priority
);
   // Idle levels at time zero
   initial begin
      {addr_out, wdata_out, wr_out, rd_out, low_out, call_out, ret_out} = '0;
      {enter_out, num_out, back_out, iv_out, inmi_out, ihf_out, iprio_out} = '0;
   end
   // One write cycle; fault flag seen in the cycle after
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic lo, output logic f);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      low_out <= lo;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
      #1 f = fault_in;
   endtask : wr
   // Control writes keep the stack bit clear while handling an exception
   task automatic wr_ctrl(input logic [31:0] d, input logic hnd, output logic f);
      wr(5'h17, hnd ? (d & 32'hFFFFFFFD) : d, 1'b0, f);
   endtask : wr_ctrl
   // One read cycle; data stands only in the following cycle
   task automatic rd(input logic [4:0] a, input logic lo, output logic [31:0] d);
      @(posedge clk_in);
      addr_out <= a;
      low_out <= lo;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      #1 d = rdata_in;
   endtask : rd
   // Call, exception entry or exception return pulse
   task automatic ev(input int k, input logic [31:0] v);
      @(posedge clk_in);
      call_out <= (k == 0);
      ret_out <= v;
      enter_out <= (k == 1);
      num_out <= v[8:0];
      back_out <= (k == 2);
      @(posedge clk_in);
      {call_out, enter_out, back_out} <= 3'h0;
   endtask : ev
   // Present a request and take the decision one edge later
   task automatic irq(input logic n, input logic h, input logic [8:0] p, output logic b);
      @(posedge clk_in);
      iv_out <= 1'b1;
      inmi_out <= n;
      ihf_out <= h;
      iprio_out <= p;
      @(posedge clk_in);
      #1 b = block_in;
   endtask : irq
endmodule : pipe_model
`default_nettype wire

// File: bench/test_cpu_core_register_file.sv
// Self-checking testbench of the core register file
`timescale 1ns/100ps
`default_nettype none
`include "cpu_regfile_consts.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module test_cpu_core_register_file;
   logic clk;
   logic rst;
   logic [31:0] d;
   logic f;
   logic b;
   int n_fail = 0;
   int num_checks = 0;
   wire logic [4:0] addr;
   wire logic [31:0] wdata, ret, rdata;
   wire logic wr, rd, lo, call, enter, back, iv, inmi, ihf, blk, fault, hnd, usr, psel;
   wire logic [8:0] num, iprio;
   // Design and pipeline model
   cpu_core_register_file u_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .ADDR_IN(addr), .WDATA_IN(wdata),
      .WR_IN(wr), .RD_IN(rd), .LOW_ONLY_IN(lo), .CALL_IN(call), .CALL_RET_ADDR_IN(ret),
      .EXC_ENTER_IN(enter), .EXC_NUM_IN(num), .EXC_RETURN_IN(back), .IRQ_VALID_IN(iv),
      .IRQ_NMI_IN(inmi), .IRQ_HARD_FAULT_IN(ihf), .IRQ_PRIO_IN(iprio), .RDATA_OUT(rdata),
      .IRQ_BLOCK_OUT(blk), .FAULT_OUT(fault), .HANDLER_MODE_OUT(hnd), .USER_LEVEL_OUT(usr),
      .PROC_SP_SEL_OUT(psel));
   pipe_model u_pm (.clk_in(clk), .rdata_in(rdata), .fault_in(fault), .block_in(blk), .addr_out(addr),
      .wdata_out(wdata), .wr_out(wr), .rd_out(rd), .low_out(lo), .call_out(call), .ret_out(ret),
      .enter_out(enter), .num_out(num), .back_out(back), .iv_out(iv), .inmi_out(inmi), .ihf_out(ihf),
      .iprio_out(iprio));
   // Counts and verdict
   task automatic close_out();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : close_out
   // Core clock, 100 ns period
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Watchdog, well beyond the roughly 160 cycles of the tests
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      $display("watchdog expired");
      close_out();
   end
   // Test sequence
   initial begin
      rst = 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      u_pm.rd(`RF_A_STATUS, 1'b0, d); `CHK("status rst", 32'h01000000, d)
      u_pm.rd(`RF_A_CONTROL, 1'b0, d); `CHK("ctrl rst", 32'h00000000, d)
      $display("test reset done");
      for (int i = 0; i < 13; i++) begin
         u_pm.wr(i[4:0], {8'hA5, i[7:0], 8'h5A, ~i[7:0]}, 1'b0, f);
      end
      for (int i = 0; i < 13; i++) begin
         u_pm.rd(i[4:0], 1'b0, d); `CHK("gen reg", {8'hA5, i[7:0], 8'h5A, ~i[7:0]}, d)
      end
      u_pm.wr(5'h08, 32'h11111111, 1'b1, f);
      u_pm.rd(5'h08, 1'b0, d); `CHK("high slot kept", 32'hA5085AF7, d)
      u_pm.rd(5'h08, 1'b1, d); `CHK("high slot short", 32'h00000000, d)
      u_pm.rd(5'h07, 1'b1, d); `CHK("low slot short", 32'hA5075AF8, d)
      $display("test general done");
      u_pm.wr(`RF_A_SP, 32'h1234567F, 1'b0, f);
      u_pm.rd(`RF_A_SP, 1'b0, d); `CHK("sp align", 32'h1234567C, d)
      u_pm.wr(`RF_A_IP, 32'h00000101, 1'b0, f);
      u_pm.rd(`RF_A_IP, 1'b0, d); `CHK("ip align", 32'h00000100, d)
      u_pm.ev(0, 32'h00002003);
      u_pm.rd(`RF_A_LINK, 1'b0, d); `CHK("link call", 32'h00002002, d)
      $display("test pointers done");
      u_pm.wr(`RF_A_STATUS, 32'hFFFFFFFF, 1'b0, f); `CHK("fault ok", 1'b0, f)
      u_pm.rd(`RF_A_STATUS, 1'b0, d); `CHK("status all", 32'hFF00FC00, d)
      u_pm.rd(`RF_A_FLAGS, 1'b0, d); `CHK("flags view", 32'hF8000000, d)
      u_pm.rd(`RF_A_EXEC, 1'b0, d); `CHK("exec view", 32'h0700FC00, d)
      u_pm.wr(`RF_A_STATUS, 32'h00000000, 1'b0, f); `CHK("fault bit24", 1'b1, f)
      u_pm.rd(`RF_A_STATUS, 1'b0, d); `CHK("status kept", 32'hFF00FC00, d)
      u_pm.wr(`RF_A_FLAGS, 32'h00000000, 1'b0, f);
      u_pm.rd(`RF_A_STATUS, 1'b0, d); `CHK("flags cleared", 32'h0700FC00, d)
      $display("test status done");
      u_pm.wr(`RF_A_MAIN_SP, 32'h00000100, 1'b0, f);
      u_pm.wr(`RF_A_PROC_SP, 32'h00000200, 1'b0, f);
      u_pm.wr_ctrl(32'h00000003, 1'b0, f);
      u_pm.rd(`RF_A_SP, 1'b0, d); `CHK("proc sp", 32'h00000200, d)
      `CHK("user lvl", 1'b1, usr)
      `CHK("proc sel", 1'b1, psel)
      u_pm.wr(`RF_A_PRIORITY_MASK_BIT, 32'h00000001, 1'b0, f); `CHK("user fault", 1'b1, f)
      u_pm.ev(1, 32'h00000003);
      u_pm.rd(`RF_A_SP, 1'b0, d); `CHK("main sp", 32'h00000100, d)
      u_pm.rd(`RF_A_EXCNUM, 1'b0, d); `CHK("exc num", 32'h00000003, d)
      `CHK("handler", 1'b1, hnd)
      u_pm.wr_ctrl(32'h00000000, 1'b1, f);
      u_pm.rd(`RF_A_PRIORITY_MASK_BIT, 1'b0, d); `CHK("priority_mask_bit kept", 32'h00000000, d)
      u_pm.ev(2, 32'h00000000);
      u_pm.rd(`RF_A_STATUS, 1'b0, d); `CHK("exc cleared", 32'h0700FC00, d)
      `CHK("thread", 1'b0, hnd)
      `CHK("priv lvl", 1'b0, usr)
      $display("test modes done");
      u_pm.wr(`RF_A_PRIORITY_MASK_BIT, 32'h00000001, 1'b0, f);
      u_pm.irq(1'b0, 1'b0, 9'h005, b); `CHK("pm ord", 1'b1, b)
      u_pm.irq(1'b0, 1'b1, 9'h005, b); `CHK("pm hf", 1'b0, b)
      u_pm.irq(1'b1, 1'b0, 9'h005, b); `CHK("pm nmi", 1'b0, b)
      u_pm.wr(`RF_A_PRIORITY_MASK_BIT, 32'h00000000, 1'b0, f);
      u_pm.wr(`RF_A_FAULT_MASK_BIT, 32'h00000001, 1'b0, f);
      u_pm.irq(1'b0, 1'b1, 9'h005, b); `CHK("fm hf", 1'b1, b)
      u_pm.irq(1'b1, 1'b0, 9'h005, b); `CHK("fm nmi", 1'b0, b)
      u_pm.wr(`RF_A_FAULT_MASK_BIT, 32'h00000000, 1'b0, f);
      u_pm.irq(1'b0, 1'b0, 9'h1FF, b); `CHK("no mask", 1'b0, b)
      u_pm.wr(`RF_A_BASE_PRIORITY_THRESHOLD, 32'h00000004, 1'b0, f);
      u_pm.irq(1'b0, 1'b0, 9'h004, b); `CHK("bp equal", 1'b1, b)
      u_pm.irq(1'b0, 1'b0, 9'h005, b); `CHK("bp above", 1'b1, b)
      u_pm.irq(1'b0, 1'b0, 9'h003, b); `CHK("bp below", 1'b0, b)
      u_pm.rd(`RF_A_BASE_PRIORITY_THRESHOLD, 1'b0, d); `CHK("bp read", 32'h00000004, d)
      $display("test masks done");
      close_out();
   end
endmodule : test_cpu_core_register_file
`default_nettype wire

// File: design/cpu_core_register_file.sv
// Architectural register file of the embedded processor core
//
// Overview of operation
// RQ1 - Sixteen core register slots numbered 0 to 15, each 32 bits wide.
// RQ2 - Slots 0-7 always selectable; 8-12 refused when encoding names low slots only.
// RQ3 - Slot 13 uses process stack only in user thread mode, else main stack.
// RQ4 - Stack pointer low two bits ignored and read as zero.
// RQ5 - Slot 14 is the return link, loaded with return address on call.
// RQ6 - Slot 15 is the instruction pointer, bit 0 ignored and read as zero.
// RQ7 - Status word readable and writable whole or as three separate parts. The code leaves the exception number part read-only.
// RQ8 - Arithmetic flags live in status bits 31 down to 27.
// RQ9 - Current exception number shown in status bits 8 down to 0.
// RQ10 - Execution state held in status bits 15-10 and 26-25.
// RQ11 - Status bit 24 reads one; clearing it faults and leaves it set.
// RQ12 - Priority mask blocks all but unmaskable interrupt and hard fault.
// RQ13 - Fault mask blocks everything except the unmaskable interrupt.
// RQ14 - Nonzero threshold blocks interrupts with priority value at or above it.
// RQ15 - Control bit 0 selects privileged (0) or user (1) thread level.
// RQ16 - Control bit 1 selects alternate stack; kept zero in handler mode. The code only refuses writing 1 there; a bit already set stays set on entry.
// RQ17 - General registers written on rising edge, read back next cycle.
`timescale 1ns/100ps
`default_nettype none
`include "cpu_regfile_consts.svh"
module cpu_core_register_file import cpu_regfile_pkg::*; (
   input wire logic CLK_IN, // Core clock, 10 MHz
   input wire logic SYS_RST_IN, // Synchronous reset, active high
   input wire logic [4:0] ADDR_IN, // Register index
   input wire logic [31:0] WDATA_IN, // Write data
   input wire logic WR_IN, // Write strobe
   input wire logic RD_IN, // Read strobe
   input wire logic LOW_ONLY_IN, // Encoding can name slots 0-7 only
   input wire logic CALL_IN, // Subroutine call pulse
   input wire logic [31:0] CALL_RET_ADDR_IN, // Return address of the call
   input wire logic EXC_ENTER_IN, // Exception entry pulse
   input wire logic [8:0] EXC_NUM_IN, // Number of the entered exception
   input wire logic EXC_RETURN_IN, // Exception return pulse
   input wire logic IRQ_VALID_IN, // Exception request pending
   input wire logic IRQ_NMI_IN, // Request is the unmaskable interrupt
   input wire logic IRQ_HARD_FAULT_IN, // Request is the hard fault
   input wire logic [8:0] IRQ_PRIO_IN, // Priority value of the request
   output logic [31:0] RDATA_OUT, // Read data, one cycle after strobe
   output logic IRQ_BLOCK_OUT, // Request masked
   output logic FAULT_OUT, // Fault pulse on illegal write
   output logic HANDLER_MODE_OUT, // Core in handler mode
   output logic USER_LEVEL_OUT, // Core at user level
   output logic PROC_SP_SEL_OUT // Process stack active
);
   // Bus request bundle
   bus_req_type bus;
   assign bus = '{addr: ADDR_IN, wdata: WDATA_IN, wr: WR_IN, rd: RD_IN};

   // Storage
   logic [31:0] gen_reg [0:12]; // RQ1
   logic [31:0] main_sp_reg, proc_sp_reg, link_reg, ip_reg, rdata_reg;
   logic [4:0] flags_reg;
   logic [1:0] exec_hi_reg, ctrl_reg;
   logic [5:0] exec_lo_reg;
   logic [8:0] exc_num_reg, base_priority_threshold_reg;
   logic priority_mask_bit_reg, fault_mask_bit_reg, fault_reg, block_reg;
   logic handler_reg, user_reg, psel_reg;
   logic [31:0] rdata_next;

   // Slot 8-12 refusal for low-only encodings
   function automatic logic slot_ok(input logic [4:0] a, input logic low_only);
      slot_ok = ~(low_only & ~a[4] & (a[3:0] > `RF_LOW_LAST) & (a[3:0] <= `RF_GEN_LAST)); // RQ2
   endfunction : slot_ok

   // Mode decode
   wire handler = |exc_num_reg;
   wire user_thread = ~handler & ctrl_reg[`RF_CTRL_USER_BIT]; // RQ15
   wire sel_proc = user_thread & ctrl_reg[`RF_CTRL_STACK_BIT]; // RQ3
   wire priv = ~user_thread;
   wire [31:0] active_sp = sel_proc ? proc_sp_reg : main_sp_reg; // RQ3

   // Status word assembly
   wire [31:0] status_word = {flags_reg, exec_hi_reg, 1'b1, 8'h00, exec_lo_reg, 1'b0, exc_num_reg}; // RQ11
   wire [31:0] flags_view = {flags_reg, 27'h0000000}; // RQ8
   wire [31:0] exec_view = {5'h00, exec_hi_reg, 1'b1, 8'h00, exec_lo_reg, 10'h000}; // RQ10
   wire [31:0] excnum_view = {23'h000000, exc_num_reg}; // RQ9

   // Write decode
   wire core_wr = bus.wr & ~bus.addr[4] & slot_ok(bus.addr, LOW_ONLY_IN);
   wire we_gen = core_wr & (bus.addr[3:0] <= `RF_GEN_LAST);
   wire priv_area = (bus.addr >= `RF_A_PRIORITY_MASK_BIT) & (bus.addr <= `RF_A_PROC_SP);
   wire priv_fault = bus.wr & priv_area & ~priv;
   wire st_wr = bus.wr & ((bus.addr == `RF_A_STATUS) | (bus.addr == `RF_A_EXEC));
   wire clr_fault = st_wr & ~bus.wdata[`RF_COMPACT_BIT]; // RQ11
   wire we_exec = st_wr & ~clr_fault; // RQ7
   wire we_flags = bus.wr & ((bus.addr == `RF_A_FLAGS) | ((bus.addr == `RF_A_STATUS) & ~clr_fault)); // RQ7
   wire sp_wr = core_wr & (bus.addr == `RF_A_SP);
   wire we_msp = (sp_wr & ~sel_proc) | (bus.wr & priv & (bus.addr == `RF_A_MAIN_SP));
   wire we_psp = (sp_wr & sel_proc) | (bus.wr & priv & (bus.addr == `RF_A_PROC_SP));
   wire we_ctrl = bus.wr & priv & (bus.addr == `RF_A_CONTROL);
   wire stack_bit_w = bus.wdata[`RF_CTRL_STACK_BIT] & ~handler; // RQ16
   wire [31:0] sp_wdata = bus.wdata & `RF_SP_MASK; // RQ4

   // Masking
   mask_state_type mask_st;
   irq_req_type irq_req;
   logic block_next;
   assign mask_st = '{priority_mask_bit: priority_mask_bit_reg, fault_mask_bit: fault_mask_bit_reg, base_priority_threshold: base_priority_threshold_reg};
   assign irq_req = '{valid: IRQ_VALID_IN, nmi: IRQ_NMI_IN, hard_fault: IRQ_HARD_FAULT_IN, prio: IRQ_PRIO_IN};
   exc_mask_eval u_mask (
      .mask_in(mask_st),
      .req_in(irq_req),
      .blocked_out(block_next)
   );

   // Read selection
   always_comb begin
      rdata_next = `RF_RST_WORD;
      if (bus.rd && slot_ok(bus.addr, LOW_ONLY_IN)) begin
         unique case (bus.addr)
            `RF_A_SP: rdata_next = active_sp; // RQ4
            `RF_A_LINK: rdata_next = link_reg; // RQ5
            `RF_A_IP: rdata_next = ip_reg; // RQ6
            `RF_A_STATUS: rdata_next = status_word; // RQ7
            `RF_A_FLAGS: rdata_next = flags_view;
            `RF_A_EXCNUM: rdata_next = excnum_view;
            `RF_A_EXEC: rdata_next = exec_view;
            `RF_A_PRIORITY_MASK_BIT: rdata_next = {31'h00000000, priority_mask_bit_reg};
            `RF_A_FAULT_MASK_BIT: rdata_next = {31'h00000000, fault_mask_bit_reg};
            `RF_A_BASE_PRIORITY_THRESHOLD: rdata_next = {23'h000000, base_priority_threshold_reg};
            `RF_A_CONTROL: rdata_next = {30'h00000000, ctrl_reg};
            `RF_A_MAIN_SP: rdata_next = main_sp_reg;
            `RF_A_PROC_SP: rdata_next = proc_sp_reg;
            default: begin
               if (bus.addr[4] == 1'b0) begin
                  rdata_next = gen_reg[bus.addr[3:0]]; // RQ17
               end
            end
         endcase
      end
   end

   // General registers, one process per slot
   genvar gi;
   generate
      for (gi = 0; gi <= 12; gi++) begin : g_gen
         always_ff @(posedge CLK_IN) begin
            if (SYS_RST_IN) begin
               gen_reg[gi] <= `RF_RST_WORD;
            end else if (we_gen && (bus.addr[3:0] == 4'(gi))) begin
               gen_reg[gi] <= bus.wdata; // RQ17
            end
         end
      end
   endgenerate

   // Banked stack pointers, stored aligned
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         main_sp_reg <= `RF_RST_WORD;
         proc_sp_reg <= `RF_RST_WORD;
      end else begin
         if (we_msp) main_sp_reg <= sp_wdata; // RQ4
         if (we_psp) proc_sp_reg <= sp_wdata; // RQ3
      end
   end

   // Return link and instruction pointer; a call wins over a bus write
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         link_reg <= `RF_RST_WORD;
         ip_reg <= `RF_RST_WORD;
      end else begin
         if (CALL_IN) link_reg <= CALL_RET_ADDR_IN & `RF_IP_MASK; // RQ5
         else if (core_wr && bus.addr == `RF_A_LINK) link_reg <= bus.wdata;
         if (core_wr && bus.addr == `RF_A_IP) ip_reg <= bus.wdata & `RF_IP_MASK; // RQ6
      end
   end

   // Status sub-registers
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         flags_reg <= `RF_RST_FLAGS;
         exec_hi_reg <= `RF_RST_EXEC_HI;
         exec_lo_reg <= `RF_RST_EXEC_LO;
      end else begin
         if (we_flags) flags_reg <= bus.wdata[`RF_FLAGS_HI:`RF_FLAGS_LO]; // RQ8
         if (we_exec) begin
            exec_hi_reg <= bus.wdata[`RF_EXEC_HI_HI:`RF_EXEC_HI_LO]; // RQ10
            exec_lo_reg <= bus.wdata[`RF_EXEC_LO_HI:`RF_EXEC_LO_LO]; // RQ10
         end
      end
   end

   // Exception number follows entry and return; entry wins
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) exc_num_reg <= `RF_RST_EXCNUM;
      else if (EXC_ENTER_IN) exc_num_reg <= EXC_NUM_IN; // RQ9
      else if (EXC_RETURN_IN) exc_num_reg <= `RF_RST_EXCNUM;
   end

   // Mask and control registers, privileged writes only
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         priority_mask_bit_reg <= `RF_RST_BIT;
         fault_mask_bit_reg <= `RF_RST_BIT;
         base_priority_threshold_reg <= `RF_RST_BASE_PRIORITY_THRESHOLD;
         ctrl_reg <= `RF_RST_CTRL;
      end else if (bus.wr && priv) begin
         if (bus.addr == `RF_A_PRIORITY_MASK_BIT) priority_mask_bit_reg <= bus.wdata[0]; // RQ12
         if (bus.addr == `RF_A_FAULT_MASK_BIT) fault_mask_bit_reg <= bus.wdata[0]; // RQ13
         if (bus.addr == `RF_A_BASE_PRIORITY_THRESHOLD) base_priority_threshold_reg <= bus.wdata[8:0]; // RQ14
         if (we_ctrl) ctrl_reg <= {stack_bit_w, bus.wdata[`RF_CTRL_USER_BIT]}; // RQ15
      end
   end

   // Registered outputs
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         rdata_reg <= `RF_RST_WORD;
         fault_reg <= 1'b0;
         block_reg <= 1'b0;
         handler_reg <= 1'b0;
         user_reg <= 1'b0;
         psel_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         fault_reg <= clr_fault | priv_fault; // RQ11
         block_reg <= block_next; // RQ12
         handler_reg <= handler;
         user_reg <= user_thread;
         psel_reg <= sel_proc;
      end
   end

   assign RDATA_OUT = rdata_reg;
   assign FAULT_OUT = fault_reg;
   assign IRQ_BLOCK_OUT = block_reg;
   assign HANDLER_MODE_OUT = handler_reg;
   assign USER_LEVEL_OUT = user_reg;
   assign PROC_SP_SEL_OUT = psel_reg;

   // Checks on the register file
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   AST_SP_ALIGNED: assert property (main_sp_reg[1:0] == 2'h0 && proc_sp_reg[1:0] == 2'h0) // RQ4
      else $error("Stack pointer lost word alignment");
   AST_IP_ALIGNED: assert property (ip_reg[0] == 1'b0) // RQ6
      else $error("Instruction pointer lost halfword alignment");
   AST_COMPACT_READ: assert property (RD_IN && ADDR_IN == `RF_A_STATUS |=> RDATA_OUT[24]) // RQ11
      else $error("Status bit 24 read as zero");
   AST_FAULT_ON_CLEAR: assert property (WR_IN && ADDR_IN == `RF_A_STATUS && !WDATA_IN[24]
      |=> FAULT_OUT && $stable(exec_lo_reg) && $stable(flags_reg)) // RQ11
      else $error("Clearing bit 24 did not fault or changed state");
   AST_CALL_LINK: assert property (CALL_IN |=> link_reg == ($past(CALL_RET_ADDR_IN) & `RF_IP_MASK)) // RQ5
      else $error("Return link not loaded on call");
   AST_READ_AFTER_WRITE: assert property (WR_IN && ADDR_IN <= 5'h07 ##1 RD_IN && ADDR_IN == $past(ADDR_IN)
      |=> RDATA_OUT == $past(WDATA_IN, 2)) // RQ17
      else $error("Read did not return last written value");
   AST_PROC_READ: assert property (RD_IN && ADDR_IN == `RF_A_SP && !LOW_ONLY_IN
      |=> RDATA_OUT == ($past(sel_proc) ? $past(proc_sp_reg) : $past(main_sp_reg))) // RQ3
      else $error("Wrong stack pointer copy read");
   AST_NMI_PASSES: assert property (IRQ_VALID_IN && IRQ_NMI_IN |=> !IRQ_BLOCK_OUT) // RQ13
      else $error("Unmaskable interrupt was blocked");
   AST_HARD_FAULT: assert property (IRQ_VALID_IN && IRQ_HARD_FAULT_IN && !IRQ_NMI_IN
      |=> IRQ_BLOCK_OUT == $past(fault_mask_bit_reg)) // RQ12
      else $error("Hard fault masking wrong");
   AST_THRESHOLD: assert property (IRQ_VALID_IN && !IRQ_NMI_IN && !IRQ_HARD_FAULT_IN && !priority_mask_bit_reg && !fault_mask_bit_reg
      |=> IRQ_BLOCK_OUT == $past(base_priority_threshold_reg != 9'h000 && IRQ_PRIO_IN >= base_priority_threshold_reg)) // RQ14
      else $error("Threshold masking wrong");
   AST_HANDLER_STACK: assert property (handler |-> !sel_proc ##1 !PROC_SP_SEL_OUT) // RQ16
      else $error("Process stack active in handler mode");
   AST_USER_WRITE_FAULT: assert property (WR_IN && user_thread && ADDR_IN == `RF_A_PRIORITY_MASK_BIT
      |=> FAULT_OUT && $stable(priority_mask_bit_reg)) // RQ15
      else $error("User level write to a mask register was not refused");
   AST_SHORT_HIGH_SLOT: assert property (RD_IN && LOW_ONLY_IN && ADDR_IN == 5'h08 |=> RDATA_OUT == 32'h00000000) // RQ2
      else $error("Short encoding reached a high slot");

   COV_CALL: cover property (CALL_IN ##1 RD_IN && ADDR_IN == `RF_A_LINK);
   COV_FAULT: cover property (FAULT_OUT);
   COV_PROC_SP: cover property (PROC_SP_SEL_OUT ##1 RD_IN && ADDR_IN == `RF_A_SP);
   COV_BLOCKED: cover property (IRQ_BLOCK_OUT && base_priority_threshold_reg != 9'h000);
endmodule : cpu_core_register_file
`default_nettype wire

// File: design/exc_mask_eval.sv
// Decides whether a pending exception is held off by the masking registers
`timescale 1ns/100ps
`default_nettype none
module exc_mask_eval import cpu_regfile_pkg::*; (
   input wire mask_state_type mask_in, // Current mask registers
   input wire irq_req_type req_in, // Pending exception
   output logic blocked_out // High when the request is masked
);
   // Threshold masking only applies to ordinary interrupts
   wire base_on = |mask_in.base_priority_threshold; // RQ14
   wire base_hit = base_on & ~req_in.hard_fault & (req_in.prio >= mask_in.base_priority_threshold); // RQ14
   wire pri_hit = mask_in.priority_mask_bit & ~req_in.hard_fault; // RQ12
   wire flt_hit = mask_in.fault_mask_bit; // RQ13
   // The unmaskable interrupt always passes
   assign blocked_out = req_in.valid & ~req_in.nmi & (flt_hit | pri_hit | base_hit); // RQ12
endmodule : exc_mask_eval
`default_nettype wire

// File: include/cpu_regfile_consts.svh
// Register indices, field positions, reset values and masks of the core register file
`ifndef CPU_REGFILE_CONSTS_SVH
`define CPU_REGFILE_CONSTS_SVH
`define RF_A_SP 5'h0D
`define RF_A_LINK 5'h0E
`define RF_A_IP 5'h0F
`define RF_A_STATUS 5'h10
`define RF_A_FLAGS 5'h11
`define RF_A_EXCNUM 5'h12
`define RF_A_EXEC 5'h13
`define RF_A_PRIORITY_MASK_BIT 5'h14
`define RF_A_FAULT_MASK_BIT 5'h15
`define RF_A_BASE_PRIORITY_THRESHOLD 5'h16
`define RF_A_CONTROL 5'h17
`define RF_A_MAIN_SP 5'h18
`define RF_A_PROC_SP 5'h19
`define RF_LOW_LAST 4'h7
`define RF_GEN_LAST 4'hC
`define RF_FLAGS_HI 31
`define RF_FLAGS_LO 27
`define RF_EXEC_HI_HI 26
`define RF_EXEC_HI_LO 25
`define RF_COMPACT_BIT 24
`define RF_EXEC_LO_HI 15
`define RF_EXEC_LO_LO 10
`define RF_EXCNUM_HI 8
`define RF_EXCNUM_LO 0
`define RF_CTRL_USER_BIT 0
`define RF_CTRL_STACK_BIT 1
`define RF_RST_WORD 32'h00000000
`define RF_RST_FLAGS 5'h00
`define RF_RST_EXEC_HI 2'h0
`define RF_RST_EXEC_LO 6'h00
`define RF_RST_EXCNUM 9'h000
`define RF_RST_BIT 1'b0
`define RF_RST_BASE_PRIORITY_THRESHOLD 9'h000
`define RF_RST_CTRL 2'h0
`define RF_SP_MASK 32'hFFFFFFFC
`define RF_IP_MASK 32'hFFFFFFFE
`endif

// File: include/cpu_regfile_pkg.sv
// Types shared by the core register file and its mask evaluator
package cpu_regfile_pkg;
   typedef struct packed {
      logic [4:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_type;
   typedef struct packed {
      logic valid;
      logic nmi;
      logic hard_fault;
      logic [8:0] prio;
   } irq_req_type;
   typedef struct packed {
      logic priority_mask_bit;
      logic fault_mask_bit;
      logic [8:0] base_priority_threshold;
   } mask_state_type;
endpackage : cpu_regfile_pkg
